//--- inc/lpsc_cfg.svh
`ifndef LPSC_CFG_SVH
`define LPSC_CFG_SVH
// Stop-grant entry bound after the acknowledge response phase, in bus clocks
`define LPSC_SG_ENTRY_CLKS 5'h14
`define LPSC_NUM_CORES 2
`define LPSC_NUM_DIES 1
`define LPSC_RATIO_W 6
`define LPSC_VID_W 7
`define LPSC_EVT_W 5
// Idle level of every synchronised pin, so leaving reset shows no false edge
`define LPSC_PIN_IDLE 10'h227
// Latched event bit positions
`define LPSC_EVT_SMI 0
`define LPSC_EVT_INIT 1
`define LPSC_EVT_BUS_INIT_ERROR_N 2
`define LPSC_EVT_LINT0 3
`define LPSC_EVT_LINT1 4
`endif

//--- inc/lpsc_pkg.sv
`include "lpsc_cfg.svh"
package lpsc_pkg;
  typedef enum logic [3:0] {
    LPSC_NORMAL = 4'h0,
    LPSC_HALT = 4'h1,
    LPSC_DH_RATIO = 4'h2,
    LPSC_DH_VID = 4'h3,
    LPSC_DEEP_HALT = 4'h4,
    LPSC_DX_VID = 4'h5,
    LPSC_DX_RATIO = 4'h6,
    LPSC_SG_ACK = 4'h7,
    LPSC_SG_WAIT = 4'h8,
    LPSC_STOP_GRANT = 4'h9,
    LPSC_SNOOP = 4'ha
  } lpsc_state_t;
endpackage : lpsc_pkg

//--- hw/lpsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_cfg.svh"
module lpsc_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic stop_clock_request_n_i,
  input wire logic sys_mgmt_interrupt_n_i,
  input wire logic soft_init_n_i,
  input wire logic bus_init_error_n_i,
  input wire logic [1:0] local_interrupt_pins_i,
  input wire logic hard_reset_n_i,
  input wire logic [`LPSC_NUM_CORES-1:0] core_halt_i,
  input wire logic deeper_halt_enable_i,
  input wire logic smm_resume_halt_i,
  input wire logic smm_resume_i,
  input wire logic fsb_interrupt_i,
  input wire logic snoop_i,
  input wire logic snoop_done_i,
  input wire logic [`LPSC_RATIO_W-1:0] nominal_ratio_i,
  input wire logic [`LPSC_RATIO_W-1:0] lowest_ratio_i,
  input wire logic [`LPSC_VID_W-1:0] nominal_vid_i,
  input wire logic [`LPSC_VID_W-1:0] low_vid_i,
  input wire logic sbc_issued_i,
  input wire logic sbc_response_i,
  output logic sbc_request_o,
  output logic [`LPSC_NUM_CORES-1:0] core_clock_run_o,
  output logic [`LPSC_RATIO_W-1:0] core_ratio_o,
  output logic [`LPSC_VID_W-1:0] voltage_id_code_o,
  output logic stop_grant_o,
  output logic snoop_ack_o,
  output logic core_init_o,
  output logic [`LPSC_EVT_W-1:0] service_event_o,
  output logic fsb_interrupt_service_o,
  output logic pending_break_event_n_o
);

  // Pins from outside: three flops, change accepted when stages two and three agree
  localparam int PW = 10;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
  assign pin_raw = {hard_reset_n_i, snoop_done_i, snoop_i, fsb_interrupt_i, stop_clock_request_n_i,
                    local_interrupt_pins_i, bus_init_error_n_i, soft_init_n_i, sys_mgmt_interrupt_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_sync
      assign pin_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : pin_reg[gi];
    end
  endgenerate
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg <= `LPSC_PIN_IDLE;
      s2_reg <= `LPSC_PIN_IDLE;
      s3_reg <= `LPSC_PIN_IDLE;
      pin_reg <= `LPSC_PIN_IDLE;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  wire logic [`LPSC_EVT_W-1:0] evt_now = {pin_reg[4], pin_reg[3], ~pin_reg[2], ~pin_reg[1], ~pin_reg[0]};
  wire logic stop_clock_request_n = ~pin_reg[5];
  wire logic fsb_int = pin_reg[6];
  wire logic snp = pin_reg[7];
  wire logic snp_done = pin_reg[8];
  wire logic hrst = ~pin_reg[9];

  lpsc_pkg::lpsc_state_t state_reg, state_next, ret_reg, ret_next;
  // Own flag for the stop-grant origin, since a snoop reuses the return state
  logic sg_halt_reg;
  logic [1:0] die_reg, die_next;
  logic [`LPSC_EVT_W-1:0] evt_prev_reg, latch_reg, latch_next;
  logic int_latch_reg, int_latch_next;
  logic low_ratio_reg, low_vid_reg;

  wire logic [`LPSC_EVT_W-1:0] evt_rise = evt_now & ~evt_prev_reg;
  wire logic all_halted = &core_halt_i;
  wire logic at_lowest = (nominal_ratio_i == lowest_ratio_i);
  wire logic go_deep = all_halted && deeper_halt_enable_i && !at_lowest;
  wire logic wake = (|evt_rise) || fsb_int;
  wire logic in_sg = (state_reg == lpsc_pkg::LPSC_STOP_GRANT);
  wire logic in_sg_area = in_sg || (state_reg == lpsc_pkg::LPSC_SG_WAIT) ||
                          (state_reg == lpsc_pkg::LPSC_SG_ACK) ||
                          (state_reg == lpsc_pkg::LPSC_SNOOP && ret_reg == lpsc_pkg::LPSC_STOP_GRANT);
  wire logic in_normal = (state_reg == lpsc_pkg::LPSC_NORMAL);
  wire logic in_halt_any = (state_reg == lpsc_pkg::LPSC_HALT) || (state_reg == lpsc_pkg::LPSC_DEEP_HALT);
  wire logic deep_path = (state_reg == lpsc_pkg::LPSC_DH_RATIO) || (state_reg == lpsc_pkg::LPSC_DH_VID) ||
                         (state_reg == lpsc_pkg::LPSC_DEEP_HALT) ||
                         (state_reg == lpsc_pkg::LPSC_SNOOP && ret_reg == lpsc_pkg::LPSC_DEEP_HALT);
  wire logic deep_exit = (state_reg == lpsc_pkg::LPSC_DX_VID) || (state_reg == lpsc_pkg::LPSC_DX_RATIO);

  always_comb
  begin
    state_next = state_reg;
    ret_next = ret_reg;
    die_next = die_reg;
    unique case (state_reg)
      lpsc_pkg::LPSC_NORMAL:
        if (stop_clock_request_n)
        begin
          state_next = lpsc_pkg::LPSC_SG_ACK;
          ret_next = lpsc_pkg::LPSC_NORMAL;
          die_next = 2'h0;
        end
        else if (go_deep)
          state_next = lpsc_pkg::LPSC_DH_RATIO;
        else if (all_halted)
          state_next = lpsc_pkg::LPSC_HALT;
      lpsc_pkg::LPSC_HALT:
        if (stop_clock_request_n)
        begin
          state_next = lpsc_pkg::LPSC_SG_ACK;
          ret_next = lpsc_pkg::LPSC_HALT;
          die_next = 2'h0;
        end
        else if (snp)
        begin
          state_next = lpsc_pkg::LPSC_SNOOP;
          ret_next = lpsc_pkg::LPSC_HALT;
        end
        else if (wake || !all_halted)
          state_next = lpsc_pkg::LPSC_NORMAL;
      lpsc_pkg::LPSC_DH_RATIO:
        state_next = lpsc_pkg::LPSC_DH_VID;
      lpsc_pkg::LPSC_DH_VID:
        state_next = lpsc_pkg::LPSC_DEEP_HALT;
      lpsc_pkg::LPSC_DEEP_HALT:
        if (snp)
        begin
          state_next = lpsc_pkg::LPSC_SNOOP;
          ret_next = lpsc_pkg::LPSC_DEEP_HALT;
        end
        else if (wake || stop_clock_request_n || !all_halted)
          state_next = lpsc_pkg::LPSC_DX_VID;
      lpsc_pkg::LPSC_DX_VID:
        state_next = lpsc_pkg::LPSC_DX_RATIO;
      lpsc_pkg::LPSC_DX_RATIO:
        state_next = lpsc_pkg::LPSC_NORMAL;
      lpsc_pkg::LPSC_SG_ACK:
        if (sbc_issued_i)
        begin
          if (die_reg == 2'(`LPSC_NUM_DIES - 1))
            state_next = lpsc_pkg::LPSC_SG_WAIT;
          else
            die_next = die_reg + 2'h1;
        end
      lpsc_pkg::LPSC_SG_WAIT:
        if (sbc_response_i)
          state_next = lpsc_pkg::LPSC_STOP_GRANT;
      lpsc_pkg::LPSC_STOP_GRANT:
        if (snp)
        begin
          state_next = lpsc_pkg::LPSC_SNOOP;
          ret_next = lpsc_pkg::LPSC_STOP_GRANT;
        end
        else if (!stop_clock_request_n)
          state_next = sg_halt_reg ? lpsc_pkg::LPSC_HALT : lpsc_pkg::LPSC_NORMAL;
      lpsc_pkg::LPSC_SNOOP:
        if (snp_done)
          state_next = ret_reg;
      default:
        state_next = lpsc_pkg::LPSC_NORMAL;
    endcase
    // Handler return chooses where execution resumes
    if (in_normal && smm_resume_i && smm_resume_halt_i)
      state_next = lpsc_pkg::LPSC_HALT;
    // Hard reset: leave halt at once, but stop-grant persists; a lowered point is restored on the way
    if (hrst && !in_sg_area && !deep_exit)
      state_next = deep_path ? lpsc_pkg::LPSC_DX_VID : lpsc_pkg::LPSC_NORMAL;
  end

  // Events latched during stop-grant: clear wins, one instance each, drained on normal
  assign latch_next = in_normal ? (evt_rise & {`LPSC_EVT_W{1'b0}}) : (latch_reg | (in_sg_area ? evt_rise : 5'h00));
  assign int_latch_next = in_normal ? 1'b0 : (int_latch_reg | (in_sg_area && fsb_int));

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= lpsc_pkg::LPSC_NORMAL;
      ret_reg <= lpsc_pkg::LPSC_NORMAL;
      sg_halt_reg <= 1'b0;
      die_reg <= 2'h0;
      evt_prev_reg <= 5'h00;
      latch_reg <= 5'h00;
      int_latch_reg <= 1'b0;
      low_ratio_reg <= 1'b0;
      low_vid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      if (state_reg != lpsc_pkg::LPSC_SG_ACK && state_next == lpsc_pkg::LPSC_SG_ACK)
        sg_halt_reg <= (state_reg == lpsc_pkg::LPSC_HALT);
      die_reg <= die_next;
      evt_prev_reg <= evt_now;
      latch_reg <= latch_next;
      int_latch_reg <= int_latch_next;
      if (state_reg == lpsc_pkg::LPSC_DH_RATIO)
        low_ratio_reg <= 1'b1;
      else if (state_reg == lpsc_pkg::LPSC_DX_RATIO)
        low_ratio_reg <= 1'b0;
      if (state_reg == lpsc_pkg::LPSC_DH_VID)
        low_vid_reg <= 1'b1;
      else if (state_reg == lpsc_pkg::LPSC_DX_VID)
        low_vid_reg <= 1'b0;
    end
  end

  // Events seen outside stop-grant are serviced directly; latched ones replay on return to normal
  logic [`LPSC_EVT_W-1:0] svc_reg;
  logic fsvc_reg, init_reg, pbe_n_reg;
  logic [`LPSC_RATIO_W-1:0] ratio_reg;
  logic [`LPSC_VID_W-1:0] vid_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      svc_reg <= 5'h00;
      fsvc_reg <= 1'b0;
      init_reg <= 1'b0;
      pbe_n_reg <= 1'b1;
      ratio_reg <= '0;
      vid_reg <= '0;
    end
    else
    begin
      svc_reg <= in_normal ? (latch_reg | evt_rise) : (in_sg_area ? 5'h00 : evt_rise);
      fsvc_reg <= in_normal ? (int_latch_reg | fsb_int) : (!in_sg_area && fsb_int);
      init_reg <= hrst;
      pbe_n_reg <= ~(in_sg && ((|latch_reg) || int_latch_reg));
      ratio_reg <= low_ratio_reg ? lowest_ratio_i : nominal_ratio_i;
      vid_reg <= low_vid_reg ? low_vid_i : nominal_vid_i;
    end
  end

  assign sbc_request_o = (state_reg == lpsc_pkg::LPSC_SG_ACK);
  assign stop_grant_o = in_sg;
  assign snoop_ack_o = (state_reg == lpsc_pkg::LPSC_SNOOP);
  generate
    for (gi = 0; gi < `LPSC_NUM_CORES; gi++)
    begin : g_core
      // Each core gates only its own clock
      assign core_clock_run_o[gi] = !core_halt_i[gi] && !in_sg_area;
    end
  endgenerate
  assign core_ratio_o = ratio_reg;
  assign voltage_id_code_o = vid_reg;
  assign core_init_o = init_reg;
  assign service_event_o = svc_reg;
  assign fsb_interrupt_service_o = fsvc_reg;
  assign pending_break_event_n_o = pbe_n_reg;

  // Wait counter stays small: the response marks entry, bound checked below
  logic [4:0] sgw_cnt_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sgw_cnt_reg <= 5'h0;
    else if (state_reg == lpsc_pkg::LPSC_SG_WAIT && sbc_response_i)
      sgw_cnt_reg <= 5'h1;
    else if (sgw_cnt_reg != 5'h0 && !in_sg)
      sgw_cnt_reg <= sgw_cnt_reg + 5'h1;
    else
      sgw_cnt_reg <= 5'h0;
  end

  a_sg_entry_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    sgw_cnt_reg <= `LPSC_SG_ENTRY_CLKS) else $error("stop-grant entry too late");
  sequence s_enter_ratio;
    state_reg == lpsc_pkg::LPSC_DH_RATIO && state_next == lpsc_pkg::LPSC_DH_VID;
  endsequence
  a_entry_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_enter_ratio |=> low_ratio_reg && !low_vid_reg ##1 low_vid_reg) else $error("ratio not lowered before voltage");
  sequence s_exit_vid;
    state_reg == lpsc_pkg::LPSC_DX_VID;
  endsequence
  a_exit_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_exit_vid |=> !low_vid_reg && low_ratio_reg ##1 !low_ratio_reg) else $error("voltage not restored first");
  a_deep_needs_all: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    state_next == lpsc_pkg::LPSC_DH_RATIO && state_reg == lpsc_pkg::LPSC_NORMAL |-> all_halted && deeper_halt_enable_i)
    else $error("deeper halt without all cores halted");
  a_lowest_ratio: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    at_lowest |-> state_next != lpsc_pkg::LPSC_DH_RATIO) else $error("deeper halt at lowest ratio");
  a_pbe_pending: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    in_sg && int_latch_reg |=> !pending_break_event_n_o) else $error("pending break event not shown");
  a_reset_keeps_sg: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    in_sg && hrst && stop_clock_request_n && !snp |=> in_sg) else $error("reset left stop-grant");
  a_snoop_return: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    snoop_ack_o && snp_done && !hrst |=> state_reg == $past(ret_reg)) else $error("snoop did not return to origin");
  a_halt_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    state_reg == lpsc_pkg::LPSC_HALT && hrst |=> in_normal) else $error("reset did not leave halt");
endmodule : lpsc_ctrl
`default_nettype wire

//--- dv/lpsc_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpsc_chipset_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic sbc_request_i,
  input wire logic snoop_ack_i,
  output logic sbc_issued_o,
  output logic sbc_response_o,
  output logic snoop_done_o
);
  logic [3:0] wait_reg;
  logic [1:0] phase_reg;
  // Slow mode models a busy bus that defers both bus phases
  wire [3:0] gap = slow_i ? 4'h7 : 4'h1;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wait_reg <= 4'h0;
      phase_reg <= 2'h0;
      sbc_issued_o <= 1'b0;
      sbc_response_o <= 1'b0;
      snoop_done_o <= 1'b0;
    end
    else
    begin
      // Bus cycles stay inactive unless one is being issued
      sbc_issued_o <= 1'b0;
      sbc_response_o <= 1'b0;
      // Level kept while acknowledged, since the design resynchronises it
      snoop_done_o <= snoop_ack_i;
      if (wait_reg != 4'h0)
        wait_reg <= wait_reg - 4'h1;
      else if (phase_reg == 2'h0 && sbc_request_i)
      begin
        phase_reg <= 2'h1;
        wait_reg <= gap;
      end
      else if (phase_reg == 2'h1)
      begin
        sbc_issued_o <= 1'b1;
        phase_reg <= 2'h2;
        wait_reg <= gap;
      end
      else if (phase_reg == 2'h2)
      begin
        sbc_response_o <= 1'b1;
        phase_reg <= 2'h0;
        wait_reg <= 4'h4;
      end
    end
  end
endmodule : lpsc_chipset_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_cfg.svh"
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic stop_clock_request_n_i = 1'b1;
  logic hard_reset_n_i = 1'b1;
  logic [4:0] evt_drv = 5'h00;
  logic [1:0] core_halt_i = 2'h0;
  logic deeper_halt_enable_i = 1'b0;
  logic fsb_interrupt_i = 1'b0;
  logic snoop_i = 1'b0;
  logic slow_i = 1'b1;
  logic smm_resume_halt_i = 1'b0;
  logic smm_resume_i = 1'b0;
  logic [5:0] nominal_ratio_i = 6'h10;
  logic [5:0] lowest_ratio_i = 6'h06;
  logic [6:0] nominal_vid_i = 7'h40;
  logic [6:0] low_vid_i = 7'h20;
  wire sys_mgmt_interrupt_n_i = ~evt_drv[`LPSC_EVT_SMI];
  wire soft_init_n_i = ~evt_drv[`LPSC_EVT_INIT];
  wire bus_init_error_n_i = ~evt_drv[`LPSC_EVT_BUS_INIT_ERROR_N];
  wire [1:0] local_interrupt_pins_i = evt_drv[4:3];
  logic snoop_done_i, sbc_issued_i, sbc_response_i, sbc_request_o, stop_grant_o, snoop_ack_o;
  logic core_init_o, fsb_interrupt_service_o, pending_break_event_n_o;
  logic [1:0] core_clock_run_o;
  logic [5:0] core_ratio_o;
  logic [6:0] voltage_id_code_o;
  logic [4:0] service_event_o;
  logic [4:0] expect_q[$];
  logic [4:0] exp_evt;
  int n_mismatch = 0;
  int samples_checked = 0;
  int i;
  int issued_cnt = 0;
  integer seed = 32'ha7df_97ff;
  lpsc_ctrl dut (.sys_clk_i, .rst_b_i, .stop_clock_request_n_i, .sys_mgmt_interrupt_n_i, .soft_init_n_i,
    .bus_init_error_n_i, .local_interrupt_pins_i, .hard_reset_n_i, .core_halt_i, .deeper_halt_enable_i,
    .smm_resume_halt_i, .smm_resume_i, .fsb_interrupt_i, .snoop_i, .snoop_done_i, .nominal_ratio_i,
    .lowest_ratio_i, .nominal_vid_i, .low_vid_i, .sbc_issued_i, .sbc_response_i, .sbc_request_o,
    .core_clock_run_o, .core_ratio_o, .voltage_id_code_o, .stop_grant_o, .snoop_ack_o, .core_init_o,
    .service_event_o, .fsb_interrupt_service_o, .pending_break_event_n_o);
  lpsc_chipset_model partner (.sys_clk_i, .rst_b_i, .slow_i, .sbc_request_i(sbc_request_o),
    .snoop_ack_i(snoop_ack_o), .sbc_issued_o(sbc_issued_i), .sbc_response_o(sbc_response_i),
    .snoop_done_o(snoop_done_i));
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    if (sbc_issued_i)
      issued_cnt++;
  end
  // Results are sampled on the falling edge, well clear of input updates
  always @(negedge sys_clk_i)
  begin
    if (rst_b_i && service_event_o !== 5'h00)
    begin
      `CHK("event outside stop grant", 1'b0, stop_grant_o)
      if (expect_q.size() == 0)
        `CHK("unexpected event", 5'h00, service_event_o)
      else
      begin
        exp_evt = expect_q.pop_front();
        `CHK("service event", exp_evt, service_event_o)
      end
    end
  end
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : settle
  task automatic pulse_evt(input int k);
    @(posedge sys_clk_i);
    evt_drv <= 5'h01 << k;
    repeat (6) @(posedge sys_clk_i);
    evt_drv <= 5'h00;
    settle(8);
  endtask : pulse_evt
  task automatic enter_sg;
    int n;
    issued_cnt = 0;
    @(posedge sys_clk_i);
    stop_clock_request_n_i <= 1'b0;
    for (i = 0; i < 60 && sbc_response_i !== 1'b1; i++) @(negedge sys_clk_i);
    for (n = 0; n < 25 && stop_grant_o !== 1'b1; n++) @(negedge sys_clk_i);
    `CHK("stop grant in time", 1'b1, n <= 20 && stop_grant_o === 1'b1)
    `CHK("all cores stopped", 2'h0, core_clock_run_o)
    `CHK("ack cycles", `LPSC_NUM_DIES, issued_cnt)
  endtask : enter_sg
  task automatic exit_sg;
    @(posedge sys_clk_i);
    // Released only once stop grant has been reached
    stop_clock_request_n_i <= 1'b1;
    for (i = 0; i < 20 && stop_grant_o !== 1'b0; i++) @(negedge sys_clk_i);
    `CHK("stop grant left", 1'b0, stop_grant_o)
  endtask : exit_sg
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    $display("Watchdog expired");
    complete_run();
  end
  initial
  begin
    @(posedge sys_clk_i);
    nominal_ratio_i <= 6'h10 + {2'h0, 4'($random(seed))};
    nominal_vid_i <= 7'h40 + {3'h0, 4'($random(seed))};
    settle(15);
    `CHK("pbe reset", 1'b1, pending_break_event_n_o)
    `CHK("vid reset", 7'h00, voltage_id_code_o)
    rst_b_i <= 1'b1;
    settle(6);
    core_halt_i <= 2'b01;
    settle(2);
    `CHK("one core halted", 2'b10, core_clock_run_o)
    core_halt_i <= 2'b11;
    for (int k = 0; k < 5; k++)
    begin
      expect_q.push_back(5'h01 << k);
      pulse_evt(k);
    end
    `CHK("wake events seen", 0, expect_q.size())
    fsb_interrupt_i <= 1'b1;
    for (i = 0; i < 20 && fsb_interrupt_service_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("bus interrupt in halt", 1'b1, fsb_interrupt_service_o)
    fsb_interrupt_i <= 1'b0;
    hard_reset_n_i <= 1'b0;
    for (i = 0; i < 10 && core_init_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("init from halt", 1'b1, core_init_o)
    hard_reset_n_i <= 1'b1;
    core_halt_i <= 2'b01;
    deeper_halt_enable_i <= 1'b1;
    settle(12);
    $display("Test halt done");
    `CHK("one core keeps ratio", nominal_ratio_i, core_ratio_o)
    core_halt_i <= 2'b11;
    for (i = 0; i < 20 && core_ratio_o !== lowest_ratio_i; i++) @(negedge sys_clk_i);
    `CHK("vid after ratio", nominal_vid_i, voltage_id_code_o)
    for (i = 0; i < 20 && voltage_id_code_o !== low_vid_i; i++) @(negedge sys_clk_i);
    `CHK("vid lowered", low_vid_i, voltage_id_code_o)
    snoop_i <= 1'b1;
    for (i = 0; i < 20 && snoop_ack_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("snoop in deep halt", 1'b1, snoop_ack_o)
    `CHK("snoop keeps ratio", lowest_ratio_i, core_ratio_o)
    snoop_i <= 1'b0;
    for (i = 0; i < 20 && snoop_ack_o !== 1'b0; i++) @(negedge sys_clk_i);
    `CHK("back to deep halt", low_vid_i, voltage_id_code_o)
    expect_q.push_back(5'h01);
    evt_drv <= 5'h01;
    for (i = 0; i < 30 && voltage_id_code_o !== nominal_vid_i; i++) @(negedge sys_clk_i);
    `CHK("ratio after vid", lowest_ratio_i, core_ratio_o)
    for (i = 0; i < 20 && core_ratio_o !== nominal_ratio_i; i++) @(negedge sys_clk_i);
    `CHK("ratio restored", nominal_ratio_i, core_ratio_o)
    evt_drv <= 5'h00;
    core_halt_i <= 2'b00;
    nominal_ratio_i <= lowest_ratio_i;
    settle(8);
    core_halt_i <= 2'b11;
    settle(12);
    `CHK("lowest ratio plain halt", nominal_vid_i, voltage_id_code_o)
    core_halt_i <= 2'b00;
    deeper_halt_enable_i <= 1'b0;
    settle(8);
    $display("Test deeper halt done");
    enter_sg();
    hard_reset_n_i <= 1'b0;
    for (i = 0; i < 10 && core_init_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("init in stop grant", 1'b1, core_init_o)
    hard_reset_n_i <= 1'b1;
    settle(6);
    `CHK("stays in stop grant", 1'b1, stop_grant_o)
    fsb_interrupt_i <= 1'b1;
    for (i = 0; i < 30 && pending_break_event_n_o !== 1'b0; i++) @(negedge sys_clk_i);
    `CHK("pending break", 1'b0, pending_break_event_n_o)
    fsb_interrupt_i <= 1'b0;
    expect_q.push_back(5'h04);
    pulse_evt(2);
    pulse_evt(2);
    snoop_i <= 1'b1;
    for (i = 0; i < 30 && snoop_ack_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("grant snoop", 1'b1, snoop_ack_o)
    snoop_i <= 1'b0;
    for (i = 0; i < 30 && stop_grant_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("snoop returns", 1'b1, stop_grant_o)
    exit_sg();
    for (i = 0; i < 30 && fsb_interrupt_service_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK("latched interrupt served", 1'b1, fsb_interrupt_service_o)
    settle(10);
    `CHK("one bus-init event", 0, expect_q.size())
    $display("Test stop grant done");
    slow_i <= 1'b0;
    core_halt_i <= 2'b11;
    settle(8);
    enter_sg();
    exit_sg();
    settle(6);
    `CHK("back in halt", 2'h0, core_clock_run_o)
    $display("Test halt stop grant done");
    core_halt_i <= 2'b00;
    nominal_ratio_i <= 6'h10;
    deeper_halt_enable_i <= 1'b1;
    settle(4);
    // Resuming into halt must not take the deeper halt path
    core_halt_i <= 2'b11;
    smm_resume_i <= 1'b1;
    smm_resume_halt_i <= 1'b1;
    settle(0);
    smm_resume_i <= 1'b0;
    settle(10);
    `CHK("resume into halt", 6'h10, core_ratio_o)
    $display("Test resume done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
